// File: logic/spi_cmd_pkg.sv
// command codes, status layout and decode helpers of the serial command port
// assumes every user imports the whole package
package spi_cmd_pkg;

	// ----------------------------------------------------------------
	// framing
	// ----------------------------------------------------------------
	localparam int         BYTE_W     = 8;
	localparam int         FIFO_DEPTH = 4;
	localparam int         SYNC_W     = 3;
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [2:0] BIT_FIRST  = 3'h0;
	localparam logic [1:0] IDX_CMD    = 2'h0;
	localparam logic [1:0] IDX_PARAM  = 2'h1;
	localparam logic [1:0] IDX_DATA   = 2'h2;
	localparam logic [1:0] IDX_MAX    = 2'h3;

	// ----------------------------------------------------------------
	// command codes
	// ----------------------------------------------------------------
	localparam logic [7:0] NO_OPERATION_CMD     = 8'hff;
	localparam logic [7:0] BUFFER_WRITE_CMD     = 8'h10;
	localparam logic [7:0] BUFFER_READ_CMD      = 8'h30;
	localparam logic [7:0] SEQ_MEM_WRITE_CMD    = 8'h18;
	localparam logic [7:0] SEQ_MEM_READ_CMD     = 8'h38;
	localparam logic [7:0] RAND_MEM_WRITE_CMD   = 8'h08;
	localparam logic [7:0] RAND_MEM_READ_CMD    = 8'h28;
	localparam logic [7:0] CODE_RAM_WRITE_CMD   = 8'h1e;
	localparam logic [7:0] GO_SLEEP_CMD         = 8'hb1;
	localparam logic [7:0] GO_IDLE_CMD          = 8'hb2;
	localparam logic [7:0] GO_PHY_STANDBY_CMD   = 8'hb3;
	localparam logic [7:0] GO_RECEIVE_CMD       = 8'hb4;
	localparam logic [7:0] GO_TRANSMIT_CMD      = 8'hb5;
	localparam logic [7:0] GO_MEASURE_CMD       = 8'hb6;
	localparam logic [7:0] CHANNEL_ASSESS_CMD   = 8'hb7;
	localparam logic [7:0] FIRMWARE_RESTART_CMD = 8'hc7;
	localparam logic [7:0] CHIP_RESET_CMD       = 8'hc8;
	// low three bits carry address bits 10:8
	localparam logic [7:0] ADDR_HI_MASK         = 8'hf8;

	// ----------------------------------------------------------------
	// status word layout
	// ----------------------------------------------------------------
	localparam int         ST_MEM_RDY  = 7;
	localparam int         ST_IRQ      = 6;
	localparam int         ST_RC_AVAIL = 5;
	localparam int         ST_CCA      = 4;
	localparam logic [3:0] STATE_RESET = 4'h0;
	localparam logic [7:0] TX_RESET    = 8'h00;

	typedef enum logic [1:0] {fr_idle, fr_cmd, fr_param} frame_e;

	function automatic logic is_radio_cmd(input logic [7:0] c);
		return (c >= GO_SLEEP_CMD && c <= CHANNEL_ASSESS_CMD) ||
			c == FIRMWARE_RESTART_CMD || c == CHIP_RESET_CMD;
	endfunction

	function automatic logic is_read_cmd(input logic [7:0] c);
		return c == BUFFER_READ_CMD ||
			(c & ADDR_HI_MASK) == SEQ_MEM_READ_CMD ||
			(c & ADDR_HI_MASK) == RAND_MEM_READ_CMD;
	endfunction

	function automatic logic is_mem_cmd(input logic [7:0] c);
		return is_read_cmd(c) || c == BUFFER_WRITE_CMD ||
			(c & ADDR_HI_MASK) == SEQ_MEM_WRITE_CMD ||
			(c & ADDR_HI_MASK) == RAND_MEM_WRITE_CMD ||
			c == CODE_RAM_WRITE_CMD;
	endfunction

endpackage

// File: logic/pin_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  logic         clock_in,
	input  logic         sys_rst_in,
	input  logic [W-1:0] pins_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// first stage feeds only the second stage
	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= pins_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule

// File: logic/sync_fifo.sv
// small flip-flop fifo with valid/ready on both sides
// assumes one clock for both sides; depth is a power of two
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  logic             clock_in,
	input  logic             sys_rst_in,
	input  logic             in_valid_in,
	output logic             in_ready_out,
	input  logic [WIDTH-1:0] in_data_in,
	output logic             out_valid_out,
	input  logic             out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_r [DEPTH];
	logic [PW-1:0]    wr_ptr_r, wr_ptr_nxt;
	logic [PW-1:0]    rd_ptr_r, rd_ptr_nxt;
	logic [PW:0]      count_r, count_nxt;
	logic             push;
	logic             pop;

	assign in_ready_out  = count_r != (PW+1)'(DEPTH);
	assign out_valid_out = count_r != '0;
	assign out_data_out  = store_r[rd_ptr_r];
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_comb begin
		wr_ptr_nxt = push ? wr_ptr_r + PW'(1) : wr_ptr_r;
		rd_ptr_nxt = pop ? rd_ptr_r + PW'(1) : rd_ptr_r;
		count_nxt  = count_r + (PW+1)'(push) - (PW+1)'(pop);
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	// data entries need no reset; valid gates them
	for (genvar i = 0; i < DEPTH; i++) begin : g_entry
		always_ff @(posedge clock_in) begin
			if (push && wr_ptr_r == PW'(i)) begin
				store_r[i] <= in_data_in;
			end
		end
	end
endmodule

// File: logic/radio_spi_command_port.sv
// serial slave command port of a radio transceiver
// assumes the serial pins come straight from the host; status and memory
// signals come from device logic on clock_in
//
// What this block does
// - drive miso only while chip select low
// - eight-bit words, most significant bit first
// - sample rising sclk, shift out falling
// - status msb on miso at select fall
// - status word returned for every byte except read data bytes of read commands
// - radio commands to radio, memory commands apart
// - radio at select rise, memory at param msb
// - state field shows completed transitions only
// - radio state command codes b1 to b7
// - chip reset c8, firmware restart c7
// - buffer write 10, buffer read 30
// - sequential write 18, read 38 plus address
// - random write 08, read 28 plus address
// - code ram write command is 1e
// - status bit 7 memory port ready
// - status bit 6 either interrupt line high
// - status bit 5 radio controller available
// - status bit 4 channel assessment result
// - status bits 3:0 radio state code
`timescale 1ns/1ps
module radio_spi_command_port
	import spi_cmd_pkg::*;
(
	input  logic       clock_in,
	input  logic       sys_rst_in,
	input  logic       chip_sel_n_in,
	input  logic       sclk_in,
	input  logic       mosi_in,
	output logic       miso_out,
	output logic       miso_oe_out,
	input  logic       mem_ready_in,
	input  logic       int_line_one_in,
	input  logic       int_line_two_in,
	input  logic       radio_ctrl_avail_in,
	input  logic       cca_result_in,
	input  logic [3:0] radio_state_in,
	output logic       rc_cmd_valid_out,
	output logic [7:0] rc_cmd_out,
	output logic       chip_reset_out,
	output logic       mem_cmd_valid_out,
	output logic [7:0] mem_cmd_out,
	output logic       mem_data_valid_out,
	input  logic       mem_data_ready_in,
	output logic [7:0] mem_data_out,
	input  logic [7:0] rd_data_in,
	output logic       rd_take_out
);
	// ----------------------------------------------------------------
	// pin sampling and edges
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pins_s;
	logic              cs_s, sclk_s, mosi_s;
	logic              cs_d_r, sclk_d_r;
	logic              cs_fall, cs_rise, sclk_rise, sclk_fall;

	pin_sync #(.W(SYNC_W)) u_sync (
		.clock_in   (clock_in),
		.sys_rst_in (sys_rst_in),
		.pins_in    ({chip_sel_n_in, sclk_in, mosi_in}),
		.sync_out   (pins_s)
	);

	assign {cs_s, sclk_s, mosi_s} = pins_s;

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			// match the synchroniser's reset level, else a false fall
			// follows reset and miso is driven with select high
			cs_d_r   <= 1'b0;
			sclk_d_r <= 1'b0;
		end else begin
			cs_d_r   <= cs_s;
			sclk_d_r <= sclk_s;
		end
	end

	assign cs_fall   = !cs_s && cs_d_r;
	assign cs_rise   = cs_s && !cs_d_r;
	assign sclk_rise = !cs_s && sclk_s && !sclk_d_r;
	assign sclk_fall = !cs_s && !sclk_s && sclk_d_r;

	// ----------------------------------------------------------------
	// status word and data fifo
	// ----------------------------------------------------------------
	logic [3:0] shown_state_r, shown_state_nxt;
	logic [7:0] status_w;
	logic       fifo_in_ready;
	logic       push_valid_r, push_valid_nxt;
	logic [7:0] push_data_r, push_data_nxt;

	// memory port counts as busy while the byte fifo is full
	assign status_w[ST_MEM_RDY]  = mem_ready_in && fifo_in_ready;
	assign status_w[ST_IRQ]      = int_line_one_in || int_line_two_in;
	assign status_w[ST_RC_AVAIL] = radio_ctrl_avail_in;
	assign status_w[ST_CCA]      = cca_result_in;
	assign status_w[3:0]         = shown_state_r;

	sync_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock_in      (clock_in),
		.sys_rst_in    (sys_rst_in),
		.in_valid_in   (push_valid_r),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (push_data_r),
		.out_valid_out (mem_data_valid_out),
		.out_ready_in  (mem_data_ready_in),
		.out_data_out  (mem_data_out)
	);

	// ----------------------------------------------------------------
	// frame decoder
	// ----------------------------------------------------------------
	frame_e     frame_r, frame_nxt;
	logic [2:0] bit_cnt_r, bit_cnt_nxt;
	logic [1:0] byte_idx_r, byte_idx_nxt;
	logic [7:0] rx_sh_r, rx_sh_nxt;
	logic [7:0] tx_sh_r, tx_sh_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic       byte_done_r, byte_done_nxt;
	logic       rc_valid_r, rc_valid_nxt;
	logic [7:0] rc_cmd_r, rc_cmd_nxt;
	logic       chip_rst_r, chip_rst_nxt;
	logic       mem_valid_r, mem_valid_nxt;
	logic [7:0] mem_cmd_r, mem_cmd_nxt;
	logic       rd_take_r, rd_take_nxt;
	logic [7:0] rx_byte;
	logic [1:0] rd_first;
	logic       rd_sel;

	assign rx_byte = {rx_sh_r[6:0], mosi_s};
	// packet read data follows the command; others follow the address
	assign rd_first = cmd_r == BUFFER_READ_CMD ? IDX_PARAM : IDX_DATA;
	assign rd_sel   = frame_r == fr_param && is_read_cmd(cmd_r) &&
		byte_idx_r >= rd_first;

	always_comb begin
		frame_nxt       = frame_r;
		bit_cnt_nxt     = bit_cnt_r;
		byte_idx_nxt    = byte_idx_r;
		rx_sh_nxt       = rx_sh_r;
		tx_sh_nxt       = tx_sh_r;
		cmd_nxt         = cmd_r;
		byte_done_nxt   = byte_done_r;
		rc_valid_nxt    = 1'b0;
		rc_cmd_nxt      = rc_cmd_r;
		chip_rst_nxt    = 1'b0;
		mem_valid_nxt   = 1'b0;
		mem_cmd_nxt     = mem_cmd_r;
		rd_take_nxt     = 1'b0;
		push_valid_nxt  = 1'b0;
		push_data_nxt   = push_data_r;
		// hold the old code until the controller reports completion
		shown_state_nxt = radio_ctrl_avail_in ? radio_state_in
			: shown_state_r;
		if (cs_rise) begin
			// only a single whole byte counts as a command
			if (frame_r == fr_cmd && byte_idx_r == IDX_PARAM &&
				bit_cnt_r == BIT_FIRST && is_radio_cmd(cmd_r)) begin
				rc_valid_nxt = 1'b1;
				rc_cmd_nxt   = cmd_r;
				chip_rst_nxt = cmd_r == CHIP_RESET_CMD;
			end
			frame_nxt     = fr_idle;
			bit_cnt_nxt   = BIT_FIRST;
			byte_idx_nxt  = IDX_CMD;
			byte_done_nxt = 1'b0;
		end else if (cs_fall) begin
			frame_nxt = fr_cmd;
			tx_sh_nxt = status_w;
		end else if (frame_r != fr_idle) begin
			if (sclk_rise) begin
				rx_sh_nxt   = rx_byte;
				bit_cnt_nxt = bit_cnt_r + 3'h1;
				if (frame_r == fr_param && bit_cnt_r == BIT_FIRST &&
					byte_idx_r == IDX_PARAM) begin
					mem_valid_nxt = 1'b1;
					mem_cmd_nxt   = cmd_r;
				end
				if (bit_cnt_r == BIT_LAST) begin
					byte_done_nxt = 1'b1;
					if (byte_idx_r != IDX_MAX) begin
						byte_idx_nxt = byte_idx_r + 2'h1;
					end
					if (byte_idx_r == IDX_CMD) begin
						cmd_nxt = rx_byte;
						if (is_mem_cmd(rx_byte)) begin
							frame_nxt = fr_param;
						end
					end else if (frame_r == fr_param &&
						fifo_in_ready) begin
						push_valid_nxt = 1'b1;
						push_data_nxt  = rx_byte;
					end
				end
			end
			if (sclk_fall) begin
				if (byte_done_r) begin
					byte_done_nxt = 1'b0;
					if (rd_sel) begin
						tx_sh_nxt   = rd_data_in;
						rd_take_nxt = 1'b1;
					end else begin
						tx_sh_nxt = status_w;
					end
				end else begin
					tx_sh_nxt = {tx_sh_r[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge clock_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			frame_r       <= fr_idle;
			bit_cnt_r     <= BIT_FIRST;
			byte_idx_r    <= IDX_CMD;
			rx_sh_r       <= TX_RESET;
			tx_sh_r       <= TX_RESET;
			cmd_r         <= NO_OPERATION_CMD;
			byte_done_r   <= 1'b0;
			rc_valid_r    <= 1'b0;
			rc_cmd_r      <= NO_OPERATION_CMD;
			chip_rst_r    <= 1'b0;
			mem_valid_r   <= 1'b0;
			mem_cmd_r     <= NO_OPERATION_CMD;
			rd_take_r     <= 1'b0;
			push_valid_r  <= 1'b0;
			push_data_r   <= TX_RESET;
			shown_state_r <= STATE_RESET;
		end else begin
			frame_r       <= frame_nxt;
			bit_cnt_r     <= bit_cnt_nxt;
			byte_idx_r    <= byte_idx_nxt;
			rx_sh_r       <= rx_sh_nxt;
			tx_sh_r       <= tx_sh_nxt;
			cmd_r         <= cmd_nxt;
			byte_done_r   <= byte_done_nxt;
			rc_valid_r    <= rc_valid_nxt;
			rc_cmd_r      <= rc_cmd_nxt;
			chip_rst_r    <= chip_rst_nxt;
			mem_valid_r   <= mem_valid_nxt;
			mem_cmd_r     <= mem_cmd_nxt;
			rd_take_r     <= rd_take_nxt;
			push_valid_r  <= push_valid_nxt;
			push_data_r   <= push_data_nxt;
			shown_state_r <= shown_state_nxt;
		end
	end

	assign miso_out          = tx_sh_r[7];
	assign miso_oe_out       = frame_r != fr_idle;
	assign rc_cmd_valid_out  = rc_valid_r;
	assign rc_cmd_out        = rc_cmd_r;
	assign chip_reset_out    = chip_rst_r;
	assign mem_cmd_valid_out = mem_valid_r;
	assign mem_cmd_out       = mem_cmd_r;
	assign rd_take_out       = rd_take_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (sys_rst_in);

	a_miso_idle_off: assert property (
		cs_s && !cs_fall |=> !miso_oe_out)
		else $error("miso driven with select high");
	a_status_msb_first: assert property (
		cs_fall |=> miso_oe_out && miso_out == $past(status_w[ST_MEM_RDY]))
		else $error("status msb missing at select fall");
	a_shift_msb_first: assert property (
		frame_r != fr_idle && sclk_fall && !byte_done_r && !cs_rise
		|=> tx_sh_r[7] == $past(tx_sh_r[6]))
		else $error("miso not shifted on falling edge");
	a_sample_rise: assert property (
		frame_r != fr_idle && sclk_rise && !cs_rise
		|=> rx_sh_r[0] == $past(mosi_s))
		else $error("mosi not sampled on rising edge");
	a_status_reload: assert property (
		frame_r != fr_idle && sclk_fall && byte_done_r && !rd_sel &&
		!cs_rise |=> tx_sh_r == $past(status_w))
		else $error("status word not reloaded for next byte");
	a_radio_at_rise: assert property (
		rc_valid_r |-> $past(cs_rise) && is_radio_cmd(rc_cmd_r))
		else $error("radio command issued outside select rise");
	a_mem_at_param: assert property (
		mem_valid_r |-> $past(sclk_rise) && is_mem_cmd(mem_cmd_r) &&
		$past(byte_idx_r) == IDX_PARAM && $past(bit_cnt_r) == BIT_FIRST)
		else $error("memory command issued at wrong edge");
	a_state_hold: assert property (
		!radio_ctrl_avail_in |=> status_w[3:0] == $past(status_w[3:0]))
		else $error("state field moved during transition");
	a_fresh_frame: assert property (
		cs_rise |=> bit_cnt_r == BIT_FIRST && byte_idx_r == IDX_CMD &&
		frame_r == fr_idle)
		else $error("decoder not cleared at select rise");
	a_irq_bit: assert property (
		cs_fall && (int_line_one_in || int_line_two_in)
		|=> tx_sh_r[ST_IRQ])
		else $error("interrupt bit not shown");

	c_radio_cmd:  cover property (rc_valid_r);
	c_mem_cmd:    cover property (mem_valid_r);
	c_read_data:  cover property (rd_take_r);
	c_fifo_full:  cover property (!fifo_in_ready);
endmodule

// File: tb/spi_host_model.sv
// host side of the serial link: master that frames, clocks and shifts bytes
// assumes one caller at a time; pin edges are kept off the system clock edge
`timescale 1ns/1ps
module spi_host_model #(
	parameter realtime HALF = 62.5
) (
	output logic chip_sel_n_out,
	output logic sclk_out,
	output logic mosi_out,
	input  wire  miso_in
);
	logic [7:0] rx_byte;
	event       byte_done;

	// ----------------------------------------------------------------
	// idle levels
	// ----------------------------------------------------------------
	// serial clock stands low between frames, select idles high
	initial begin
		chip_sel_n_out = 1'h1;
		sclk_out = 1'h0;
		mosi_out = 1'h0;
		rx_byte = 8'h00;
	end

	// ----------------------------------------------------------------
	// framing and shifting
	// ----------------------------------------------------------------
	task automatic open_frame();
		#3;
		chip_sel_n_out = 1'h0;
		#(HALF);
	endtask

	// one command per select low period
	task automatic close_frame();
		#(HALF);
		chip_sel_n_out = 1'h1;
		// released data line must not look stable to the device
		mosi_out = ~mosi_out;
		#(4 * HALF);
	endtask

	task automatic shift_bits(input logic [7:0] tx, input int n);
		for (int i = 7; i > 7 - n; i--) begin
			mosi_out = tx[i];
			#(HALF);
			sclk_out = 1'h1;
			rx_byte[i] = miso_in;
			#(HALF);
			sclk_out = 1'h0;
		end
		if (n == 8) begin
			-> byte_done;
		end
	endtask
endmodule

// File: tb/radio_spi_command_port_tb.sv
// self-checking bench of the serial command port: host model on the link,
// status, command and fifo results checked against expectation queues
// assumes the package, the design files and the host model compile first
`timescale 1ns/1ps
module radio_spi_command_port_tb
	import spi_cmd_pkg::*;
;
	localparam logic [7:0] RC_CODES [9] = '{GO_SLEEP_CMD, GO_IDLE_CMD,
		GO_PHY_STANDBY_CMD, GO_RECEIVE_CMD, GO_TRANSMIT_CMD, GO_MEASURE_CMD,
		CHANNEL_ASSESS_CMD, FIRMWARE_RESTART_CMD, CHIP_RESET_CMD};
	localparam logic [7:0] MEM_CODES [7] = '{BUFFER_WRITE_CMD,
		BUFFER_READ_CMD, SEQ_MEM_WRITE_CMD, SEQ_MEM_READ_CMD,
		RAND_MEM_WRITE_CMD, RAND_MEM_READ_CMD, CODE_RAM_WRITE_CMD};
	// first byte index that returns read data, 0 for writes
	localparam int         RD_TAB [7]    = '{0, 1, 0, 2, 0, 2, 0};

	logic       clock_in, sys_rst_in;
	logic       chip_sel_n, sclk, mosi, miso, miso_oe;
	wire        miso_line;
	logic       mem_ready, int_one, int_two, rc_avail, cca, rd_take;
	logic [3:0] state, shown;
	logic       rc_valid, chip_reset, mem_valid, data_valid, data_ready;
	logic [7:0] rc_cmd, mem_cmd, data_out, rd_data, rc_exp;
	logic [7:0] seed = 8'h1f;
	logic [7:0] q_status[$], q_rc[$], q_mem[$], q_data[$], q_take[$];
	int         err_count = 0;
	int         checks = 0;

	assign miso_line = miso_oe ? miso : 1'bz;

	radio_spi_command_port i_radio_spi_command_port (
		.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.chip_sel_n_in(chip_sel_n), .sclk_in(sclk), .mosi_in(mosi),
		.miso_out(miso), .miso_oe_out(miso_oe), .mem_ready_in(mem_ready),
		.int_line_one_in(int_one), .int_line_two_in(int_two),
		.radio_ctrl_avail_in(rc_avail), .cca_result_in(cca),
		.radio_state_in(state), .rc_cmd_valid_out(rc_valid),
		.rc_cmd_out(rc_cmd), .chip_reset_out(chip_reset),
		.mem_cmd_valid_out(mem_valid), .mem_cmd_out(mem_cmd),
		.mem_data_valid_out(data_valid), .mem_data_ready_in(data_ready),
		.mem_data_out(data_out), .rd_data_in(rd_data),
		.rd_take_out(rd_take));

	spi_host_model i_spi_host_model (
		.chip_sel_n_out(chip_sel_n), .sclk_out(sclk), .mosi_out(mosi),
		.miso_in(miso_line));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] next_rand();
		seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
		return seed;
	endfunction

	// an empty queue yields unknown so an unexpected result always fails
	function automatic logic [7:0] pop(ref logic [7:0] q[$]);
		return (q.size() != 0) ? q.pop_front() : 8'hxx;
	endfunction

	task automatic cmp_word(input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic cmp_flag(input logic e, input logic g);
		cmp_word({7'h00, e}, {7'h00, g});
	endtask

	function automatic logic [7:0] exp_status(input int fill);
		return {mem_ready && fill < FIFO_DEPTH, int_one | int_two, rc_avail,
			cca, shown};
	endfunction

	// status inputs change only between frames so loads are predictable
	task automatic set_status(input logic [7:0] r);
		@(posedge clock_in);
		int_one <= r[0];
		int_two <= r[1];
		rc_avail <= r[2];
		mem_ready <= r[3];
		cca <= r[4];
		state <= {1'h0, r[7:5]};
		rd_data <= next_rand();
		repeat (4) @(posedge clock_in);
		if (rc_avail) begin
			shown = state;
		end
	endtask

	// kind: 0 nothing executes, 1 radio command, 2 memory command
	task automatic run_frame(input logic [7:0] b[$], input int kind,
		input int rd_from, input logic stall);
		int fill;
		if (kind == 1) q_rc.push_back(b[0]);
		if (kind == 2) q_mem.push_back(b[0]);
		i_spi_host_model.open_frame();
		foreach (b[i]) begin
			// bytes 1 to i-1, at most FIFO_DEPTH of them, sit in the stalled fifo when byte i loads
			fill = (stall && i > 0) ?
				((i <= FIFO_DEPTH) ? i - 1 : FIFO_DEPTH) : 0;
			if (rd_from != 0 && i >= rd_from) begin
				q_status.push_back(rd_data);
				q_take.push_back(rd_data);
			end else begin
				q_status.push_back(exp_status(fill));
			end
			if (kind == 2 && i > 0 && fill < FIFO_DEPTH) q_data.push_back(b[i]);
			i_spi_host_model.shift_bits(b[i], 8);
		end
		// the last falling edge already fetches one more read byte
		if (rd_from != 0) q_take.push_back(rd_data);
		i_spi_host_model.close_frame();
		cmp_flag(1'h0, miso_oe);
	endtask

	task automatic stop_test();
		if (q_status.size() + q_rc.size() + q_mem.size() + q_data.size() +
			q_take.size() != 0)
			err_count++;
		$display("checks %0d err_count %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// result watchers
	// ----------------------------------------------------------------
	always @(i_spi_host_model.byte_done) begin
		cmp_word(pop(q_status), i_spi_host_model.rx_byte);
		cmp_flag(1'h1, miso_oe);
	end

	always @(posedge clock_in) begin
		if (rc_valid === 1'h1) begin
			rc_exp = pop(q_rc);
			cmp_word(rc_exp, rc_cmd);
			cmp_flag(rc_exp === CHIP_RESET_CMD, chip_reset);
			cmp_flag(1'h1, chip_sel_n);
		end
		if (mem_valid === 1'h1) begin
			cmp_word(pop(q_mem), mem_cmd);
			cmp_flag(1'h0, chip_sel_n);
		end
		if (data_valid === 1'h1 && data_ready === 1'h1)
			cmp_word(pop(q_data), data_out);
		if (rd_take === 1'h1)
			cmp_word(pop(q_take), rd_data);
	end

	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clock_in = 1'h0;
		forever #5 clock_in = ~clock_in;
	end

	// normal run is under 100 us; five times that means a hang
	initial begin
		#500000;
		err_count++;
		stop_test();
	end

	initial begin
		logic [7:0] r;
		logic [7:0] b[$];
		sys_rst_in = 1'h1;
		{int_one, int_two, rc_avail, mem_ready, cca} = 5'h00;
		state = 4'h0;
		rd_data = 8'h00;
		data_ready = 1'h1;
		shown = STATE_RESET;
		repeat (12) @(posedge clock_in);
		sys_rst_in <= 1'h0;
		repeat (4) @(posedge clock_in);
		cmp_flag(1'h0, miso_oe);
		// broken byte, then a whole command must decode from bit zero
		set_status(8'h24);
		i_spi_host_model.open_frame();
		i_spi_host_model.shift_bits(GO_IDLE_CMD, 3);
		i_spi_host_model.close_frame();
		run_frame('{GO_SLEEP_CMD}, 1, 0, 1'h0);
		// busy controller with a new state: shown state must hold
		set_status(8'ha0);
		run_frame('{NO_OPERATION_CMD, NO_OPERATION_CMD}, 0, 0, 1'h0);
		foreach (RC_CODES[k]) begin
			set_status(next_rand() | 8'h04);
			run_frame('{RC_CODES[k]}, 1, 0, 1'h0);
		end
		run_frame('{GO_IDLE_CMD, NO_OPERATION_CMD}, 0, 0, 1'h0);
		foreach (MEM_CODES[k]) begin
			r = next_rand();
			set_status(r | 8'h08);
			b = '{MEM_CODES[k] | ((k >= 2 && k <= 5) ? {5'h00, r[2:0]} : 8'h00),
				next_rand(), next_rand()};
			for (int i = RD_TAB[k]; i < 3 && RD_TAB[k] != 0; i++)
				b[i] = NO_OPERATION_CMD;
			run_frame(b, 2, RD_TAB[k], 1'h0);
		end
		// stalled far side: fifo fills, ready bit drops, extra bytes lost
		set_status(next_rand() | 8'h08);
		data_ready <= 1'h0;
		b = '{BUFFER_WRITE_CMD};
		repeat (6) b.push_back(next_rand());
		run_frame(b, 2, 0, 1'h1);
		data_ready <= 1'h1;
		repeat (10) @(posedge clock_in);
		cmp_flag(1'h0, data_valid);
		set_status(next_rand() | 8'h08);
		run_frame('{NO_OPERATION_CMD}, 0, 0, 1'h0);
		stop_test();
	end
endmodule
